// [bench/refresh_timer_chk.sv]
`timescale 1ns/1ps
module refresh_timer_chk (
  input wire i_core_clk,
  input wire i_rst,
  input wire [2:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_word,
  input wire i_rd,
  input wire [15:0] o_rdata,
  input wire i_data_out_active,
  input wire o_parity_pin_upper,
  input wire o_parity_pin_lower,
  input wire o_refresh_req,
  input wire o_self_refresh,
  input wire o_match_interrupt,
  input wire [1:0] o_refresh_wait_sel
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire rc_key = i_wr && i_word && i_addr == 3'h0 && i_wdata[15:8] == 8'h5a;
  wire cs_w = i_wr && i_addr == 3'h1;
  rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0)
    else $error("read data not zero outside read");
  upper_zero_a: assert property ($past(i_rd && i_addr < 3'h4) |->
    o_rdata[15:8] == 8'h0) else $error("upper byte not zero");
  par_low_a: assert property ($past(i_rd && i_addr == 3'h4) |->
    o_rdata[10:0] == 11'h0) else $error("parity low bits not zero");
  req_pulse_a: assert property (o_refresh_req |=> !o_refresh_req)
    else $error("refresh request longer than one cycle");
  req_mode_a: assert property (o_refresh_req |-> !$past(o_self_refresh))
    else $error("refresh request in self refresh");
  self_key_a: assert property ($changed(o_self_refresh) |-> $past(rc_key))
    else $error("self refresh changed without keyed write");
  wait_key_a: assert property ($changed(o_refresh_wait_sel) |->
    $past(rc_key)) else $error("wait select changed without keyed write");
  byte_refuse_a: assert property (cs_w && !i_word && o_match_interrupt
    |=> o_match_interrupt) else $error("byte write changed status");
  irq_off_a: assert property (cs_w && i_word && i_wdata[15:8] == 8'ha5 &&
    !i_wdata[6] |=> !o_match_interrupt) else $error("interrupt not masked");
  pin_idle_a: assert property (!$past(i_data_out_active) |->
    !o_parity_pin_upper && !o_parity_pin_lower) else $error("pins not idle");
  cover property (o_refresh_req);
  cover property (o_match_interrupt);
  cover property (o_self_refresh);
endmodule
bind refresh_timer_parity_ctrl refresh_timer_chk refresh_timer_chk_inst (.*);

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
  reg i_core_clk = 0, i_rst = 1, i_wr = 0, i_word = 0, i_rd = 0;
  reg [2:0] i_addr = 0;
  reg [15:0] i_wdata = 0, i_data_out = 0, i_data_in = 0, v, c;
  reg [1:0] i_data_in_par = 0;
  reg i_data_out_active = 0, i_data_in_check = 0;
  reg i_access_dram = 0, i_access_area2 = 0;
  reg [7:0] r, d, p;
  wire [15:0] o_rdata;
  wire pu, pl, req, selfr, irq;
  wire [1:0] wsel;
  integer n_errors = 0, total_checks = 0, seed = 32'h5038, i, k, t, x;
  always #50 i_core_clk = ~i_core_clk;
  refresh_timer_parity_ctrl refresh_timer_parity_ctrl_inst (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_word(i_word), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_data_out(i_data_out),
    .i_data_out_active(i_data_out_active), .i_data_in(i_data_in),
    .i_data_in_par(i_data_in_par), .i_data_in_check(i_data_in_check),
    .i_access_dram(i_access_dram), .i_access_area2(i_access_area2),
    .o_parity_pin_upper(pu), .o_parity_pin_lower(pl),
    .o_refresh_req(req), .o_self_refresh(selfr),
    .o_match_interrupt(irq), .o_refresh_wait_sel(wsel));
  function [7:0] key(input integer a);
    key = a == 0 ? 8'h5a : a == 1 ? 8'ha5 : a == 2 ? 8'h69 : 8'h96;
  endfunction
  function [1:0] pins(input [15:0] c, input [15:0] d, input dr, input a2);
    reg g;
    begin
      g = (c[12:11] == 2'h1 && dr) || (c[12:11] == 2'h2 && (dr || a2));
      pins = c[14] ? 2'h3 : g ? {^d[15:8], ^d[7:0]} ^ {2{c[13]}} : 2'h0;
    end
  endfunction
  task chk(input [15:0] s, input [15:0] e);
    begin
      total_checks = total_checks + 1;
      if (s !== e) begin
        n_errors = n_errors + 1;
        $display("BAD %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task wr(input [2:0] a, input [15:0] dat, input w);
    begin
      @(posedge i_core_clk);
      i_addr <= a;
      i_wdata <= dat;
      i_word <= w;
      i_wr <= 1;
      @(posedge i_core_clk);
      i_wr <= 0;
      #1;
    end
  endtask
  task rd(input [2:0] a);
    begin
      @(posedge i_core_clk);
      i_addr <= a;
      i_rd <= 1;
      @(posedge i_core_clk);
      i_rd <= 0;
      #1 v = o_rdata;
    end
  endtask
  task wait_req;
    begin
      t = 0;
      @(posedge i_core_clk) #1;
      while (req !== 1'b1 && t < 9000) begin
        @(posedge i_core_clk) #1;
        t = t + 1;
      end
      if (t >= 9000) begin
        n_errors = n_errors + 1;
        report_and_stop;
      end
    end
  endtask
  task strobe(input [1:0] par);
    begin
      @(posedge i_core_clk);
      i_data_in <= 16'h0001;
      i_data_in_par <= par;
      i_access_dram <= 1;
      i_data_in_check <= 1;
      @(posedge i_core_clk);
      i_data_in_check <= 0;
    end
  endtask
  initial begin
    repeat (5) @(posedge i_core_clk);
    i_rst <= 0;
    for (i = 0; i < 6; i = i + 1) begin
      rd(i);
      chk(v, i == 3 ? 16'h00ff : 16'h0);
    end
    for (i = 0; i < 4; i = i + 1) begin
      x = $random(seed);
      d = x[7:0] & (i == 0 ? 8'hf0 : i == 1 ? 8'h40 : i == 2 ? 8'h7f : 8'hff);
      wr(i, {key(i) ^ (x[15:8] | 8'h01), d}, 1);
      wr(i, {key(i), d}, 0);
      rd(i);
      chk(v, i == 3 ? 16'h00ff : 16'h0);
      wr(i, {key(i), d}, 1);
      rd(i);
      chk(v, {8'h0, d});
    end
    x = $random(seed);
    p = 8'h08 + x[2:0];
    wr(0, 16'h5a80, 1);
    wr(3, {8'h96, p}, 1);
    wr(2, 16'h6900, 1);
    wr(1, 16'ha548, 1);
    wait_req;
    wait_req;
    chk(t + 1 == 2 * p || t + 1 == 2 * p + 2, 1);
    chk(irq, 1);
    wr(1, 16'ha540, 1);
    wr(1, 16'ha540, 0);
    chk(irq, 1);
    rd(1);
    chk(v, 16'h00c0);
    wr(1, 16'ha540, 1);
    chk(irq, 0);
    wr(0, 16'h5ac0, 1);
    chk(selfr, 1);
    wr(0, 16'h5a30, 1);
    chk({selfr, wsel}, 16'h3);
    for (i = 1; i < 8; i = i + 1) begin
      k = i == 7 ? 4096 : 2 << (2 * i - 2);
      wr(2, 16'h6900, 1);
      wr(1, {8'ha5, 2'h0, i[2:0], 3'h0}, 1);
      repeat (4 * k) @(posedge i_core_clk);
      wr(1, 16'ha500, 1);
      rd(2);
      chk(v >= 3 && v <= 5, 1);
    end
    for (i = 0; i < 24; i = i + 1) begin
      x = $random(seed);
      r = x[7:0];
      c = {1'b0, r[2:1], r[4:3] == 2'h3 ? 2'h1 : r[4:3], 11'h0};
      wr(4, c, r[7]);
      @(posedge i_core_clk);
      i_data_out <= x[31:16];
      i_data_out_active <= 1;
      i_access_dram <= r[5];
      i_access_area2 <= r[6];
      @(posedge i_core_clk);
      i_data_out_active <= 0;
      #1 chk({pu, pl}, pins(c, i_data_out, r[5], r[6]));
    end
    wr(4, 16'h0800, 1);
    strobe(2'h1);
    rd(4);
    chk(v, 16'h0800);
    strobe(2'h0);
    wr(4, 16'h0800, 1);
    rd(4);
    chk(v, 16'h8800);
    wr(4, 16'h0800, 1);
    rd(4);
    chk(v, 16'h0800);
    report_and_stop;
  end
endmodule

// [logic/refresh_timer_parity_ctrl.v]
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - 8-bit counter steps on selected divided clock
// - match clears counter and sets match flag
// - match with refresh enabled and type select 0 requests refresh
// - match with irq enable raises interrupt
// - counter upper byte reads zero, never counts
// - counter cleared by power-on reset or match; keyed write loads it
// - period resets to 0x00ff at power-on only
// - compare uses low period byte only
// - parity control cleared by power-on reset only
// - parity error sticky; read-one then write-zero clears
// - force bit drives both parity pins high
// - polarity bit picks even or odd parity
// - space field selects parity coverage areas
// - protected registers accept word writes only
// - keys 0x5a control, 0xa5 control/status
// - keys 0x69 counter, 0x96 period
// - keyed write updates low byte; bad key ignored
// - byte or word reads, upper byte zero except parity control
// - source codes: off, /2 up to /4096
// - match flag held until read-one then write-zero
// - type select picks periodic or self refresh
module refresh_timer_parity_ctrl #(
  parameter CNT_W = 8
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire [2:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_word,
  input wire i_rd,
  output reg [15:0] o_rdata,
  input wire [15:0] i_data_out,
  input wire i_data_out_active,
  input wire [15:0] i_data_in,
  input wire [1:0] i_data_in_par,
  input wire i_data_in_check,
  input wire i_access_dram,
  input wire i_access_area2,
  output reg o_parity_pin_upper,
  output reg o_parity_pin_lower,
  output reg o_refresh_req,
  output wire o_self_refresh,
  output wire o_match_interrupt,
  output wire [1:0] o_refresh_wait_sel
);
`include "refresh_timer_defs.vh"

  reg [7:0] refresh_ctrl_reg_q;
  reg [7:0] tmr_csr_q;
  reg [CNT_W-1:0] refresh_tick_counter_q;
  reg [CNT_W-1:0] refresh_period_compare_q;
  reg [4:0] parity_ctrl_q;
  reg match_seen_q;
  reg perr_seen_q;
  reg [CNT_W-1:0] cnt_d;
  reg match_flag_d;
  reg perr_d;
  reg [15:0] rdata_d;

  wire tick;
  wire match;
  wire [7:0] key;
  wire wr_word;
  wire wr_rc;
  wire wr_cs;
  wire wr_cnt;
  wire wr_per;
  wire wr_pc;
  wire refresh_en;
  wire [1:0] space_sel;
  wire space_hit;
  wire polarity;
  wire gen_upper;
  wire gen_lower;
  wire chk_err;

  tick_prescaler #(
    .W(`PRESCALE_W)
  ) u_prescaler (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_src_sel(tmr_csr_q[`CS_SRC_HI:`CS_SRC_LO]),
    .o_tick(tick)
  );

  assign key = i_wdata[15:8];
  assign wr_word = i_wr & i_word;
  assign wr_rc = wr_word & (i_addr == `ADDR_RFSH_CTRL) &
    (key == `KEY_RFSH_CTRL);
  assign wr_cs = wr_word & (i_addr == `ADDR_TMR_CSR) &
    (key == `KEY_TMR_CSR);
  assign wr_cnt = wr_word & (i_addr == `ADDR_TICK_CNT) &
    (key == `KEY_TICK_CNT);
  assign wr_per = wr_word & (i_addr == `ADDR_PERIOD) &
    (key == `KEY_PERIOD);
  // parity control is an ordinary register: any write size
  assign wr_pc = i_wr & (i_addr == `ADDR_PARITY_CTRL);

  assign match = (refresh_tick_counter_q == refresh_period_compare_q);
  assign refresh_en = refresh_ctrl_reg_q[`RC_REFRESH_EN];

  // a match is acted on once per compare event, in the first cycle the counter equals it
  reg match_q;
  wire match_evt;
  assign match_evt = match & ~match_q;

  always @* begin
    cnt_d = refresh_tick_counter_q;
    if (match_evt) begin
      cnt_d = {CNT_W{1'b0}};
    end else if (tick) begin
      cnt_d = refresh_tick_counter_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
    if (wr_cnt) begin
      cnt_d = i_wdata[CNT_W-1:0];
    end
  end

  // flag: set wins over clear; clear needs an earlier read of one
  always @* begin
    match_flag_d = tmr_csr_q[`CS_MATCH_FLAG];
    if (wr_cs && match_seen_q && !i_wdata[`CS_MATCH_FLAG]) begin
      match_flag_d = 1'b0;
    end
    if (match_evt) begin
      match_flag_d = 1'b1;
    end
  end

  assign space_sel = parity_ctrl_q[`PC_SPACE_HI-11:`PC_SPACE_LO-11];
  assign space_hit =
    ((space_sel == `PC_SPACE_DRAM) & i_access_dram) |
    ((space_sel == `PC_SPACE_DRAM_A2) & (i_access_dram | i_access_area2));
  assign polarity = parity_ctrl_q[`PC_POLARITY-11];
  assign gen_upper = (^i_data_out[15:8]) ^ polarity;
  assign gen_lower = (^i_data_out[7:0]) ^ polarity;
  assign chk_err = i_data_in_check & space_hit &
    (((^i_data_in[15:8]) ^ polarity ^ i_data_in_par[1]) |
     ((^i_data_in[7:0]) ^ polarity ^ i_data_in_par[0]));

  always @* begin
    perr_d = parity_ctrl_q[`PC_ERR_FLAG-11];
    if (wr_pc && perr_seen_q && !i_wdata[`PC_ERR_FLAG]) begin
      perr_d = 1'b0;
    end
    if (chk_err) begin
      perr_d = 1'b1;
    end
  end

  always @* begin
    rdata_d = 16'h0000;
    case (i_addr)
      `ADDR_RFSH_CTRL: rdata_d[7:0] = refresh_ctrl_reg_q;
      `ADDR_TMR_CSR: rdata_d[7:0] = tmr_csr_q;
      `ADDR_TICK_CNT: rdata_d[CNT_W-1:0] = refresh_tick_counter_q;
      `ADDR_PERIOD: rdata_d[CNT_W-1:0] = refresh_period_compare_q;
      `ADDR_PARITY_CTRL: rdata_d[15:11] = parity_ctrl_q;
      default: rdata_d = 16'h0000;
    endcase
  end

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      refresh_ctrl_reg_q <= `RST_BYTE_ZERO;
      tmr_csr_q <= `RST_BYTE_ZERO;
      refresh_tick_counter_q <= {CNT_W{1'b0}};
      refresh_period_compare_q <= `RST_PERIOD;
      parity_ctrl_q <= `RST_PARITY;
      match_q <= 1'b0;
      match_seen_q <= 1'b0;
      perr_seen_q <= 1'b0;
      o_rdata <= 16'h0000;
      o_refresh_req <= 1'b0;
      o_parity_pin_upper <= 1'b0;
      o_parity_pin_lower <= 1'b0;
    end else begin
      if (wr_rc) begin
        refresh_ctrl_reg_q <= {i_wdata[7:4], 4'h0};
      end
      if (wr_cs) begin
        tmr_csr_q <= {match_flag_d, i_wdata[6:3], 3'h0};
      end else begin
        tmr_csr_q[`CS_MATCH_FLAG] <= match_flag_d;
      end
      if (wr_per) begin
        refresh_period_compare_q <= i_wdata[CNT_W-1:0];
      end
      refresh_tick_counter_q <= cnt_d;
      match_q <= match & ~wr_cnt;
      if (wr_pc) begin
        parity_ctrl_q <= {perr_d, i_wdata[14:11]};
      end else begin
        parity_ctrl_q[`PC_ERR_FLAG-11] <= perr_d;
      end
      // remember a read of one; consumed by the next accepted write to that register
      if (i_rd && i_addr == `ADDR_TMR_CSR) begin
        match_seen_q <= tmr_csr_q[`CS_MATCH_FLAG];
      end else if (wr_cs || !match_flag_d) begin
        match_seen_q <= 1'b0;
      end
      if (i_rd && i_addr == `ADDR_PARITY_CTRL) begin
        perr_seen_q <= parity_ctrl_q[`PC_ERR_FLAG-11];
      end else if (wr_pc || !perr_d) begin
        perr_seen_q <= 1'b0;
      end
      o_rdata <= i_rd ? rdata_d : 16'h0000;
      // periodic refresh only when type select is 0
      o_refresh_req <= match_evt & refresh_en &
        ~refresh_ctrl_reg_q[`RC_TYPE_SEL];
      if (i_data_out_active && parity_ctrl_q[`PC_FORCE-11]) begin
        o_parity_pin_upper <= 1'b1;
        o_parity_pin_lower <= 1'b1;
      end else if (i_data_out_active && space_hit) begin
        o_parity_pin_upper <= gen_upper;
        o_parity_pin_lower <= gen_lower;
      end else begin
        o_parity_pin_upper <= 1'b0;
        o_parity_pin_lower <= 1'b0;
      end
    end
  end

  assign o_self_refresh = refresh_en & refresh_ctrl_reg_q[`RC_TYPE_SEL];
  assign o_match_interrupt = tmr_csr_q[`CS_MATCH_FLAG] &
    tmr_csr_q[`CS_IRQ_EN];
  assign o_refresh_wait_sel = refresh_ctrl_reg_q[`RC_WAIT_HI:`RC_WAIT_LO];

endmodule

// [logic/tick_prescaler.v]
`timescale 1ns/1ps
`include "refresh_timer_defs.vh"
// free-running divider; one-cycle tick on the selected divided clock
module tick_prescaler #(
  parameter W = `PRESCALE_W
) (
  input wire i_core_clk,
  input wire i_rst,
  input wire [2:0] i_src_sel,
  output reg o_tick
);

  reg [W-1:0] div_q;
  wire [W-1:0] div_d;
  reg tap;

  assign div_d = div_q + {{(W-1){1'b0}}, 1'b1};

  // tap is high for one cycle per divided-clock period, when the selected low divider bits are all ones
  always @* begin
    case (i_src_sel)
      3'h1: tap = (div_q[`TAP_DIV2:0] == {(`TAP_DIV2+1){1'b1}});
      3'h2: tap = (div_q[`TAP_DIV8:0] == {(`TAP_DIV8+1){1'b1}});
      3'h3: tap = (div_q[`TAP_DIV32:0] == {(`TAP_DIV32+1){1'b1}});
      3'h4: tap = (div_q[`TAP_DIV128:0] == {(`TAP_DIV128+1){1'b1}});
      3'h5: tap = (div_q[`TAP_DIV512:0] == {(`TAP_DIV512+1){1'b1}});
      3'h6: tap = (div_q[`TAP_DIV2048:0] == {(`TAP_DIV2048+1){1'b1}});
      3'h7: tap = (div_q[`TAP_DIV4096:0] == {(`TAP_DIV4096+1){1'b1}});
      default: tap = 1'b0;
    endcase
  end

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      div_q <= {W{1'b0}};
      o_tick <= 1'b0;
    end else begin
      div_q <= div_d;
      o_tick <= tap;
    end
  end

endmodule

// [shared/refresh_timer_defs.vh]
`ifndef REFRESH_TIMER_DEFS_VH
`define REFRESH_TIMER_DEFS_VH

// register word addresses
`define ADDR_RFSH_CTRL 3'h0
`define ADDR_TMR_CSR 3'h1
`define ADDR_TICK_CNT 3'h2
`define ADDR_PERIOD 3'h3
`define ADDR_PARITY_CTRL 3'h4

// write keys carried in the upper byte
`define KEY_RFSH_CTRL 8'h5a
`define KEY_TMR_CSR 8'ha5
`define KEY_TICK_CNT 8'h69
`define KEY_PERIOD 8'h96

// reset values
`define RST_BYTE_ZERO 8'h00
`define RST_PERIOD 8'hff
`define RST_PARITY 5'h00

// refresh control fields
`define RC_REFRESH_EN 7
`define RC_TYPE_SEL 6
`define RC_WAIT_HI 5
`define RC_WAIT_LO 4
// timer control/status fields
`define CS_MATCH_FLAG 7
`define CS_IRQ_EN 6
`define CS_SRC_HI 5
`define CS_SRC_LO 3
// parity control fields
`define PC_ERR_FLAG 15
`define PC_FORCE 14
`define PC_POLARITY 13
`define PC_SPACE_HI 12
`define PC_SPACE_LO 11
`define PC_SPACE_OFF 2'h0
`define PC_SPACE_DRAM 2'h1
`define PC_SPACE_DRAM_A2 2'h2

// prescaler taps for tick sources 1..7
`define TAP_DIV2 0
`define TAP_DIV8 2
`define TAP_DIV32 4
`define TAP_DIV128 6
`define TAP_DIV512 8
`define TAP_DIV2048 10
`define TAP_DIV4096 11
`define PRESCALE_W 12

`endif
